// *** gpio_cfg_params.svh ***
`ifndef GPIO_CFG_PARAMS_SVH
`define GPIO_CFG_PARAMS_SVH
// register indices; the byte address is four times the index
`define PORT0_ORIENT_IDX   8'h93
`define PORT1_ORIENT_IDX   8'h94
`define PORT2_ORIENT_IDX   8'h95
`define PORT3_ORIENT_IDX   8'h96
`define PORT0_OPTIONS_IDX  8'h9E
`define PORT1_OPTIONS_IDX  8'h9F
`define PORT2_OPTIONS_IDX  8'hA0
`define PORT3_OPTIONS_IDX  8'hA1
`define ORIENT_RESET       8'hFF
`define OPTIONS_RESET      8'h00
`define OUT_MODE_NORMAL    3'h0
`define OUT_MODE_HIGH      3'h3
`define IN_MODE_RESET      2'h0
`define IN_MODE_PULL_DOWN  2'h1
`define IN_MODE_PULL_UP    2'h2
`define IN_MODE_BUF_OFF    2'h3
`define OUT_MODE_RESET     3'h0
`define PORT3_RSVD_BIT     3'h7
`define FUNC_CODE_MSB      7
`define FUNC_CODE_LSB      5
`define OPTION_SIDE_BIT    4
`define READBACK_SEL_BIT   3
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2
`endif

// *** gpio_cfg_pkg.sv ***
package gpio_cfg_pkg;
   typedef struct packed {
      logic [7:0] drive_en;   // 1 = output driver on
      logic [7:0] high_drive; // 1 = high drive strength
      logic [7:0] pull_down;
      logic [7:0] pull_up;
      logic [7:0] in_buf_on;
   } port_pads_t;
   typedef struct packed {
      logic [2:0] pin_function_code;
      logic       option_side;
      logic       readback_select;
      logic [2:0] pin_index;
   } option_word_t;
endpackage

// *** gpio_direction_option_config.sv ***
`include "gpio_cfg_params.svh"
// What this block does
// - after reset every pin is an input with its output driver off.
// - after reset each pin's input value reaches the mcu input bit.
// - a direction bit of 0 makes an output and 1 makes an input.
// - direction bit n of a port steers pin n of that port.
// - bit 7 of the port 3 direction register steers no pin.
// - each option write with readback select clear configures exactly one selected pin.
// - a readback write of pin 5 output side then reads its mode in 7:5.
// - output code 000 is normal drive and 011 high drive.
// - input code 00 plain, 01 pull-down, 10 pull-up, 11 buffer off.
// - option side 0 means output options and 1 means input options.
// - a readback write only stores index and side, ignoring the code.
module gpio_direction_option_config (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   // axi4-lite write address
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // pins
   input  wire logic [31:0]             pad_in,
   output gpio_cfg_pkg::port_pads_t     pad_ctrl [4],
   // mcu side
   output logic [31:0]                  mcu_pin_input
);
   import gpio_cfg_pkg::*;

   // stored configuration
   logic [7:0]   orient_q [4];
   logic [2:0]   out_mode_q [4][8];
   logic [1:0]   in_mode_q [4][8];
   logic [2:0]   sel_index_q [4];
   logic         sel_side_q [4];

   // write channel holding registers
   logic [11:0]  awaddr_q;
   logic         aw_held_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;
   logic         w_held_q;

   // write decode
   logic         wr_fire;
   logic [7:0]   wr_idx;
   logic         wr_hit;
   logic [1:0]   wr_port;
   logic         wr_is_opt;
   logic         dir_write;
   logic         opt_write;
   option_word_t wr_word;

   // read decode and next pad state
   logic [7:0]   rd_idx;
   logic [31:0]  rd_data;
   logic         rd_hit;
   port_pads_t   pads_d [4];

   // write fires once both halves are held and no response is pending
   assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_idx    = awaddr_q[9:2];
   assign wr_word   = option_word_t'(wdata_q[7:0]);

   // a cleared byte-0 strobe leaves every register untouched
   assign dir_write = wr_fire && wr_hit && !wr_is_opt && wstrb_q[0];
   assign opt_write = wr_fire && wr_hit && wr_is_opt && wstrb_q[0];

   // decode write target
   always_comb begin
      wr_hit    = 1'b1;
      wr_port   = 2'h0;
      wr_is_opt = 1'b0;
      unique case (wr_idx)
         `PORT0_ORIENT_IDX:  wr_port = 2'h0;
         `PORT1_ORIENT_IDX:  wr_port = 2'h1;
         `PORT2_ORIENT_IDX:  wr_port = 2'h2;
         `PORT3_ORIENT_IDX:  wr_port = 2'h3;
         `PORT0_OPTIONS_IDX: begin
            wr_port   = 2'h0;
            wr_is_opt = 1'b1;
         end
         `PORT1_OPTIONS_IDX: begin
            wr_port   = 2'h1;
            wr_is_opt = 1'b1;
         end
         `PORT2_OPTIONS_IDX: begin
            wr_port   = 2'h2;
            wr_is_opt = 1'b1;
         end
         `PORT3_OPTIONS_IDX: begin
            wr_port   = 2'h3;
            wr_is_opt = 1'b1;
         end
         default: wr_hit = 1'b0;
      endcase
   end

   // address and data channels taken in either order
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else begin
         // address half; ready is a flop mirroring the free slot
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q     <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q      <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q     <= 1'b0;
            s_axi_awready <= 1'b1;
         end
         // data half, same scheme
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q     <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // direction registers, stored as written
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         // all pins come up as inputs
         for (int p = 0; p < 4; p++) begin
            orient_q[p] <= `ORIENT_RESET;
         end
      end else if (dir_write) begin
         orient_q[wr_port] <= wdata_q[7:0];
      end
   end

   // option writes: one pin per write, or just the readback pointer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int p = 0; p < 4; p++) begin
            sel_index_q[p] <= 3'h0;
            sel_side_q[p]  <= 1'b0;
            for (int b = 0; b < 8; b++) begin
               out_mode_q[p][b] <= `OUT_MODE_RESET;
               in_mode_q[p][b]  <= `IN_MODE_RESET;
            end
         end
      end else if (opt_write) begin
         // pointer only; the code field is ignored then
         if (wr_word.readback_select) begin
            sel_index_q[wr_port] <= wr_word.pin_index;
            sel_side_q[wr_port]  <= wr_word.option_side;
         end else if (!wr_word.option_side) begin
            // illegal output codes are kept but fall back to normal drive
            out_mode_q[wr_port][wr_word.pin_index] <=
               wr_word.pin_function_code;
         end else begin
            in_mode_q[wr_port][wr_word.pin_index] <=
               wr_word.pin_function_code[1:0];
         end
      end
   end

   // read decode
   always_comb begin
      rd_idx  = s_axi_araddr[9:2];
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (rd_idx)
         `PORT0_ORIENT_IDX: rd_data[7:0] = orient_q[0];
         `PORT1_ORIENT_IDX: rd_data[7:0] = orient_q[1];
         `PORT2_ORIENT_IDX: rd_data[7:0] = orient_q[2];
         `PORT3_ORIENT_IDX: rd_data[7:0] = orient_q[3];
         `PORT0_OPTIONS_IDX, `PORT1_OPTIONS_IDX,
         `PORT2_OPTIONS_IDX, `PORT3_OPTIONS_IDX: begin
            // report the pin and side the pointer names
            for (int p = 0; p < 4; p++) begin
               if (rd_idx == `PORT0_OPTIONS_IDX + 8'(p)) begin
                  if (sel_side_q[p]) begin
                     rd_data[6:5] = in_mode_q[p][sel_index_q[p]];
                  end else begin
                     rd_data[7:5] = out_mode_q[p][sel_index_q[p]];
                  end
               end
            end
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // read channel, one cycle after the address is taken
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `AXI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid  <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // next pad controls from the stored configuration
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         // idle pattern first, then each pin from its stored codes
         pads_d[p] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
         for (int b = 0; b < 8; b++) begin
            // low bit selects pin b; port 3 top bit steers nothing
            if (p == 3 && b == `PORT3_RSVD_BIT) begin
               pads_d[p].drive_en[b] = 1'b0;
            end else begin
               pads_d[p].drive_en[b] = !orient_q[p][b];
            end
            pads_d[p].high_drive[b] =
               (out_mode_q[p][b] == `OUT_MODE_HIGH);
            pads_d[p].pull_down[b] =
               (in_mode_q[p][b] == `IN_MODE_PULL_DOWN);
            pads_d[p].pull_up[b] =
               (in_mode_q[p][b] == `IN_MODE_PULL_UP);
            pads_d[p].in_buf_on[b] =
               (in_mode_q[p][b] != `IN_MODE_BUF_OFF);
         end
      end
   end

   // pad controls registered so every output is a flip-flop
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int p = 0; p < 4; p++) begin
            pad_ctrl[p] <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
         end
      end else begin
         pad_ctrl <= pads_d;
      end
   end

   // input route to the mcu; buffer off reads zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mcu_pin_input <= 32'h0000_0000;
      end else begin
         for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
               mcu_pin_input[p*8+b] <= pad_in[p*8+b] &&
                  (in_mode_q[p][b] != `IN_MODE_BUF_OFF);
            end
         end
      end
   end

endmodule // gpio_direction_option_config

// *** gpio_cfg_checker.sv ***
module gpio_cfg_checker (
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 reset,
   // bus handshakes
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   // pins and mcu side
   input wire logic [31:0]          pad_in,
   input gpio_cfg_pkg::port_pads_t  pad_ctrl [4],
   input wire logic [31:0]          mcu_pin_input
);
   logic [31:0] buf_on;
   logic [31:0] drv;
   logic [31:0] pu;
   logic [31:0] pd;
   // flatten per-port lanes so one compare covers all pins
   assign buf_on = {pad_ctrl[3].in_buf_on, pad_ctrl[2].in_buf_on,
                    pad_ctrl[1].in_buf_on, pad_ctrl[0].in_buf_on};
   assign drv = {pad_ctrl[3].drive_en, pad_ctrl[2].drive_en,
                 pad_ctrl[1].drive_en, pad_ctrl[0].drive_en};
   assign pu = {pad_ctrl[3].pull_up, pad_ctrl[2].pull_up,
                pad_ctrl[1].pull_up, pad_ctrl[0].pull_up};
   assign pd = {pad_ctrl[3].pull_down, pad_ctrl[2].pull_down,
                pad_ctrl[1].pull_down, pad_ctrl[0].pull_down};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   reset_pins_a: assert property ($fell(reset) |->
      drv == 32'h0 && buf_on == 32'hFFFFFFFF) else $error("pins not idle");
   // buffer enable and mcu input both follow the same stored code edge
   pin_route_a: assert property ($past(!reset) |->
      mcu_pin_input == ($past(pad_in) & buf_on))
      else $error("mcu input bad");
   pull_excl_a: assert property ((pu & pd) == 32'h0 &&
      ((pu | pd) & ~buf_on) == 32'h0) else $error("pull on idle pin");
   rsvd_pin_a: assert property (pad_ctrl[3].drive_en[7] == 1'b0)
      else $error("reserved pin driven");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (pad_ctrl[0].high_drive != 8'h00);
endmodule // gpio_cfg_checker

bind gpio_direction_option_config gpio_cfg_checker u_chk (.sys_clk,
   .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_ctrl,
   .mcu_pin_input);

// *** gpio_pad_model.sv ***
module gpio_pad_model (
   // pad controls and outside world
   input gpio_cfg_pkg::port_pads_t  pad_ctrl [4],
   input wire logic [31:0]          ext_level,
   output logic [31:0]              pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // a pull only wins on a pin nobody drives; else the board level shows
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         pad_in[i] = ext_level[i];
         if (!pad_ctrl[i/8].drive_en[i%8] && pad_ctrl[i/8].pull_up[i%8])
            pad_in[i] = 1'b1;
         if (!pad_ctrl[i/8].drive_en[i%8] && pad_ctrl[i/8].pull_down[i%8])
            pad_in[i] = 1'b0;
      end
   end
endmodule // gpio_pad_model

// *** tb_gpio_direction_option_config.sv ***
`include "gpio_cfg_params.svh"
module tb_gpio_direction_option_config;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_cfg_pkg::*;
   localparam logic [31:0] EXT = 32'hA5C33C5A;
   logic sys_clk = 1'b0, reset = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] wdata = 32'h0, rdata, pad_in, mcu_pin_input, d;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   port_pads_t pad_ctrl [4];
   int err_total = 0, compares = 0;
   gpio_direction_option_config dut (.sys_clk(sys_clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pad_in(pad_in), .pad_ctrl(pad_ctrl),
      .mcu_pin_input(mcu_pin_input));
   gpio_pad_model pads (.pad_ctrl(pad_ctrl), .ext_level(EXT),
      .pad_in(pad_in));
   // free-running 50 MHz clock
   initial forever #10 sys_clk = ~sys_clk;
   task summarize();
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // handshakes sampled at the rising edge; each channel drops once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic b;
      @(posedge sys_clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, v};
      {awvalid, wvalid, bready} <= 3'b111;
      b = 1'b0;
      for (int n = 0; n < 40 && !b; n++) begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            b = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      if (!b) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] idx);
      logic v;
      @(posedge sys_clk);
      araddr <= {2'h0, idx, 2'h0};
      {arvalid, rready} <= 2'b11;
      v = 1'b0;
      for (int n = 0; n < 40 && !v; n++) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      if (!v) begin
         err_total++;
         summarize();
      end
   endtask
   // direction registers come up as inputs, pins routed to the mcu
   task t_reset();
      for (int p = 0; p < 4; p++) begin
         rd(`PORT0_ORIENT_IDX + 8'(p));
         chk(d, 32'hFF);
         chk(pad_ctrl[p].drive_en, 8'h00);
      end
      chk(mcu_pin_input, EXT);
   endtask
   // each port gets its own pattern; port 3 top bit must stay dead
   task t_dir();
      logic [7:0] v, e;
      for (int p = 0; p < 4; p++) begin
         v = 8'h3C + 8'(p);
         e = ~v & ((p == 3) ? 8'h7F : 8'hFF);
         wr(`PORT0_ORIENT_IDX + 8'(p), v);
         rd(`PORT0_ORIENT_IDX + 8'(p));
         chk(d, {24'h0, v});
         chk(pad_ctrl[p].drive_en, e);
      end
   endtask
   // readback write with code 000 must leave pin 5 on high drive
   task t_out();
      wr(`PORT0_OPTIONS_IDX, {`OUT_MODE_HIGH, 5'b00101});
      wr(`PORT0_OPTIONS_IDX, {`OUT_MODE_NORMAL, 5'b01101});
      rd(`PORT0_OPTIONS_IDX);
      chk(d, 32'h60);
      chk(pad_ctrl[0].high_drive, 8'h20);
      wr(`PORT0_OPTIONS_IDX, {`OUT_MODE_NORMAL, 5'b00101});
      rd(`PORT0_OPTIONS_IDX);
      chk(d, 32'h0);
      chk(pad_ctrl[0].high_drive, 8'h00);
   endtask
   // every input code on port 1 pin 2, an input pin with board level 1
   task t_in();
      logic [2:0] e;
      for (int c = 0; c < 4; c++) begin
         e = (c == 3) ? 3'b000 : {1'b1, c == 2, c == 1};
         wr(`PORT1_OPTIONS_IDX, {1'b0, 2'(c), 5'b10010});
         wr(`PORT1_OPTIONS_IDX, 8'h1A);
         rd(`PORT1_OPTIONS_IDX);
         chk(d, 32'(c) << 5);
         chk({pad_ctrl[1].in_buf_on[2], pad_ctrl[1].pull_up[2],
              pad_ctrl[1].pull_down[2]}, e);
         chk(pad_ctrl[1].high_drive, 8'h00);
         chk(mcu_pin_input[10], c != 3 && c != 1);
      end
   endtask
   // unmapped place answers with an error both ways
   task t_bad();
      rd(8'h10);
      chk(r, `AXI_RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h10, 8'hA5);
      chk(r, `AXI_RESP_SLVERR);
      // byte-0 strobe cleared: answered okay, register untouched
      wstrb <= 4'hE;
      wr(`PORT2_ORIENT_IDX, 8'h00);
      wstrb <= 4'hF;
      chk(r, `AXI_RESP_OKAY);
      rd(`PORT2_ORIENT_IDX);
      chk(d, 32'h3E);
   endtask
   // reset in mid-run drops every pin back to a routed input
   task t_rerun();
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(`PORT3_ORIENT_IDX);
      chk(d, 32'hFF);
      for (int p = 0; p < 4; p++) begin
         chk(pad_ctrl[p].drive_en, 8'h00);
      end
      chk(mcu_pin_input, EXT);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_dir();
      t_out();
      t_in();
      t_bad();
      t_rerun();
      summarize();
   end
endmodule // tb_gpio_direction_option_config
